// ===== rtl/lpib_pkg.sv
package lpib_pkg;
	// pwm oscillator and system clock rates
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned OSC_HZ = 32_000;
	// clocks per pwm cycle; a period rounds down to whole cycles
	localparam int unsigned CYC_CLKS = CLK_HZ / OSC_HZ;
	localparam logic [11:0] CYC_LAST = 12'(CYC_CLKS - 1);
	localparam logic [11:0] PRESC_ZERO = 12'h000;
	// 16 pwm cycles per timeslot, 15 timeslots per 240-step period
	localparam logic [3:0] CYCLE_LAST = 4'hF;
	localparam logic [3:0] SLOT_LAST = 4'hE;
	localparam logic [3:0] COUNT_ZERO = 4'h0;
	localparam logic [3:0] COUNT_ONE = 4'h1;
	// register offsets
	localparam logic [7:0] ADDR_PAT1_LOW = 8'h0A;
	localparam logic [7:0] ADDR_PAT1_HIGH = 8'h0B;
	localparam logic [7:0] ADDR_MASTER = 8'h0E;
	localparam logic [7:0] ADDR_INT_FIRST = 8'h10;
	localparam logic [7:0] ADDR_INT_LAST = 8'h17;
	// field values
	localparam logic [3:0] SET_STATIC = 4'hF;
	localparam logic [3:0] MASTER_STATIC = 4'h0;
	// reset values: patterns released, pwm off
	localparam logic [7:0] RST_PATTERN = 8'hFF;
	localparam logic [7:0] RST_INTENSITY = 8'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;
	localparam int unsigned NUM_PORTS = 16;

	// pick one nibble of an intensity byte
	function automatic logic [3:0] lpib_nibble(input logic [7:0] b,
		input logic hi);
		lpib_nibble = hi ? b[7:4] : b[3:0];
	endfunction

	// pattern level by blink phase
	function automatic logic lpib_level(input logic en, input logic phase,
		input logic p0, input logic p1);
		lpib_level = (en && phase) ? p1 : p0;
	endfunction
endpackage

// ===== rtl/lpib_timebase.sv
`timescale 1ns/10ps
module lpib_timebase import lpib_pkg::*; (
	input wire logic i_clock, // system clock
	input wire logic i_rst, // sync reset, active high
	output logic [3:0] o_cycle, // pwm cycle in slot
	output logic [3:0] o_slot // master timeslot
);
	typedef struct packed {
		logic [11:0] presc;
		logic [3:0] cycle;
		logic [3:0] slot;
	} lpib_tb_s;

	lpib_tb_s st;
	lpib_tb_s next_st;

	// prescaler stands in for the pwm oscillator
	always_comb begin
		next_st = st;
		if (st.presc == CYC_LAST) begin
			next_st.presc = PRESC_ZERO;
			if (st.cycle == CYCLE_LAST) begin
				next_st.cycle = COUNT_ZERO;
				// 15 slots then wrap
				next_st.slot = (st.slot == SLOT_LAST) ? COUNT_ZERO :
					st.slot + COUNT_ONE;
			end else begin
				next_st.cycle = st.cycle + COUNT_ONE;
			end
		end else begin
			next_st.presc = st.presc + 12'h001;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_cycle = st.cycle;
	assign o_slot = st.slot;
endmodule

// ===== rtl/lpib_out_slice.sv
`timescale 1ns/10ps
module lpib_out_slice import lpib_pkg::*; (
	input wire logic [3:0] i_setting, // effective duty setting
	input wire logic i_level, // selected pattern level
	input wire logic [3:0] i_master, // master gate field
	input wire logic [3:0] i_slot, // current timeslot
	input wire logic [3:0] i_cycle, // cycle in timeslot
	output logic o_level // level to present, 1 = released
);
	logic is_static;
	logic gate_open;
	logic on_time;

	// master zero or setting 0xF: plain static level, no glitches
	always_comb begin
		is_static = (i_master == MASTER_STATIC) ||
			(i_setting == SET_STATIC);
		gate_open = i_slot < i_master;
		on_time = gate_open && (i_cycle <= i_setting);
		// on-time carries the pattern level, otherwise its opposite
		o_level = (is_static || on_time) ? i_level : ~i_level;
	end
endmodule

// ===== rtl/lpib_top.sv
`timescale 1ns/10ps
module lpib_top import lpib_pkg::*; (
	input wire logic i_clock, // system clock, 125 MHz
	input wire logic i_rst, // sync reset, active high
	input wire logic i_reg_wr, // register write strobe
	input wire logic [7:0] i_reg_addr, // register offset
	input wire logic [7:0] i_reg_wdata, // write data
	output logic [7:0] o_reg_rdata, // read data of last address
	input wire logic [15:0] i_phase0_pattern, // phase-zero bits
	input wire logic i_o16_phase0, // seventeenth phase-zero bit
	input wire logic i_o16_phase1, // seventeenth phase-one bit
	input wire logic i_blink_enable, // blink mode on
	input wire logic i_blink_flip, // software flip flag
	input wire logic i_blink_pin, // external blink input level
	input wire logic i_global_mode, // global intensity flag
	output logic [15:0] o_port_oe, // port pulled low when high
	output logic o_seventeenth_output_oe // same for output 16
);
	typedef struct packed {
		logic [15:0] pat1;
		logic [7:0] master;
		logic [7:0][7:0] intensity;
		logic [7:0] rdata;
		logic [15:0] port_oe;
		logic o16_oe;
	} lpib_top_s;

	lpib_top_s st;
	lpib_top_s next_st;
	logic [3:0] cycle;
	logic [3:0] slot;
	logic phase;
	logic [16:0] lvl;
	logic [16:0] setting;
	logic [16:0] drive;
	logic [2:0] int_idx;

	lpib_timebase u_timebase (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.o_cycle(cycle),
		.o_slot(slot)
	);

	// phase and per-output pattern level selection
	always_comb begin
		phase = i_blink_flip ^ i_blink_pin;
		for (int i = 0; i < NUM_PORTS; i++) begin
			lvl[i] = lpib_level(i_blink_enable, phase,
				i_phase0_pattern[i], st.pat1[i]);
		end
		lvl[16] = lpib_level(i_blink_enable, phase, i_o16_phase0,
			i_o16_phase1);
	end

	// global flag hands every output the seventeenth nibble
	genvar g;
	generate
		for (g = 0; g < 17; g++) begin : g_out
			logic [3:0] own;
			logic [3:0] eff;
			if (g < 16) begin : g_port
				assign own = lpib_nibble(st.intensity[g / 2], 1'(g % 2));
			end else begin : g_o16
				assign own = st.master[3:0];
			end
			assign eff = i_global_mode ? st.master[3:0] : own;
			assign setting[g] = |eff;
			lpib_out_slice u_slice (
				.i_setting(eff),
				.i_level(lvl[g]),
				.i_master(st.master[7:4]),
				.i_slot(slot),
				.i_cycle(cycle),
				.o_level(drive[g])
			);
		end
	endgenerate

	assign int_idx = i_reg_addr[2:0];

	// register writes, read mux and registered pin enables
	always_comb begin
		next_st = st;
		if (i_reg_wr) begin
			case (i_reg_addr)
				ADDR_PAT1_LOW: next_st.pat1[7:0] = i_reg_wdata;
				ADDR_PAT1_HIGH: next_st.pat1[15:8] = i_reg_wdata;
				ADDR_MASTER: next_st.master = i_reg_wdata;
				default: begin
					if (i_reg_addr >= ADDR_INT_FIRST &&
						i_reg_addr <= ADDR_INT_LAST) begin
						next_st.intensity[int_idx] = i_reg_wdata;
					end
				end
			endcase
		end
		// reads return stored values, not pin state; others read zero
		case (i_reg_addr)
			ADDR_PAT1_LOW: next_st.rdata = st.pat1[7:0];
			ADDR_PAT1_HIGH: next_st.rdata = st.pat1[15:8];
			ADDR_MASTER: next_st.rdata = st.master;
			default: begin
				if (i_reg_addr >= ADDR_INT_FIRST &&
					i_reg_addr <= ADDR_INT_LAST) begin
					next_st.rdata = st.intensity[int_idx];
				end else begin
					next_st.rdata = READ_ZERO;
				end
			end
		endcase
		// open drain: level 1 releases, level 0 pulls low
		next_st.port_oe = ~drive[15:0];
		next_st.o16_oe = ~drive[16];
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			st.pat1 <= {RST_PATTERN, RST_PATTERN};
			st.master <= RST_INTENSITY;
			st.intensity <= {8{RST_INTENSITY}};
			st.rdata <= READ_ZERO;
			st.port_oe <= '0;
			st.o16_oe <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign o_reg_rdata = st.rdata;
	assign o_port_oe = st.port_oe;
	assign o_seventeenth_output_oe = st.o16_oe;

	// checks: outputs lag their cause by one clock
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	// written byte lands at the edge, read back one edge later
	property p_pat1_write;
		i_reg_wr && i_reg_addr == ADDR_PAT1_LOW ##1
			i_reg_addr == ADDR_PAT1_LOW && !i_reg_wr |=>
			o_reg_rdata == $past(i_reg_wdata, 2);
	endproperty
	a_pat1_write: assert property (p_pat1_write) else $error("phase-one write lost");

	property p_master_static;
		st.master[7:4] == MASTER_STATIC && !i_reg_wr |=>
			o_port_oe[0] == ~$past(lvl[0]);
	endproperty
	a_master_static: assert property (p_master_static) else $error("static master modulated");

	property p_max_static;
		!i_global_mode && st.intensity[0][3:0] == SET_STATIC && !i_reg_wr |=>
			o_port_oe[0] == ~$past(lvl[0]);
	endproperty
	a_max_static: assert property (p_max_static) else $error("max setting not static");

	property p_gate_closed;
		st.master[7:4] != MASTER_STATIC && slot >= st.master[7:4] &&
			!i_global_mode && st.intensity[0][3:0] != SET_STATIC |=>
			o_port_oe[0] == $past(lvl[0]);
	endproperty
	a_gate_closed: assert property (p_gate_closed) else $error("ungated slot active");

	property p_on_time;
		slot < st.master[7:4] && !i_global_mode &&
			cycle <= st.intensity[0][3:0] |=>
			o_port_oe[0] == ~$past(lvl[0]);
	endproperty
	a_on_time: assert property (p_on_time) else $error("on-time level wrong");

	property p_global_static;
		i_global_mode && st.master[3:0] == SET_STATIC |=>
			o_seventeenth_output_oe == ~$past(lvl[16]) &&
			o_port_oe[5] == ~$past(lvl[5]);
	endproperty
	a_global_static: assert property (p_global_static) else $error("global setting ignored");

	property p_phase_sel;
		i_blink_enable && (i_blink_flip ^ i_blink_pin) |->
			lvl[3] == st.pat1[3];
	endproperty
	a_phase_sel: assert property (p_phase_sel) else $error("blink phase wrong");

	property p_slot_range;
		slot <= SLOT_LAST && cycle <= CYCLE_LAST;
	endproperty
	a_slot_range: assert property (p_slot_range) else $error("timeslot out of range");

	c_gated_pwm: cover property (slot < st.master[7:4] && setting[0]);
	c_blink_phase1: cover property (i_blink_enable && phase);
	c_global: cover property (i_global_mode && st.master[7:4] != MASTER_STATIC);
endmodule

// ===== testbench/lpib_led_load.sv
`timescale 1ns/10ps
module lpib_led_load (
	input wire logic [16:0] i_oe, // pull-low enables from the block
	output logic [16:0] o_pin // pin level seen by the loads
);
	// resistive pull-up: a released pin floats high, never unknown
	assign o_pin = ~i_oe;
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top import lpib_pkg::*;;
	logic i_clock, i_rst, i_reg_wr, i_global_mode;
	logic i_blink_enable, i_blink_flip, i_blink_pin;
	logic i_o16_phase0, i_o16_phase1;
	logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
	logic [15:0] i_phase0_pattern, o_port_oe;
	logic o_seventeenth_output_oe;
	logic [16:0] pins, pat;
	logic [3:0] st [17];
	int fail_count, n_tests, clk_n;

	lpib_top dut (.i_clock(i_clock), .i_rst(i_rst), .i_reg_wr(i_reg_wr),
		.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
		.o_reg_rdata(o_reg_rdata), .i_phase0_pattern(i_phase0_pattern),
		.i_o16_phase0(i_o16_phase0), .i_o16_phase1(i_o16_phase1),
		.i_blink_enable(i_blink_enable), .i_blink_flip(i_blink_flip),
		.i_blink_pin(i_blink_pin), .i_global_mode(i_global_mode),
		.o_port_oe(o_port_oe),
		.o_seventeenth_output_oe(o_seventeenth_output_oe));
	lpib_led_load u_load (.i_oe({o_seventeenth_output_oe, o_port_oe}),
		.o_pin(pins));

	// clock and the clock count since reset release
	initial begin
		i_clock = 0;
		forever #4 i_clock = ~i_clock;
	end
	always @(posedge i_clock) clk_n <= i_rst ? 0 : clk_n + 1;

	task results;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk_reg(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task chk_pin(input logic [16:0] got, input logic [16:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_clock);
		i_reg_wr <= 1'b0;
	endtask
	// read data is registered: let two edges pass before looking
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_clock);
		i_reg_addr <= a;
		repeat (2) @(posedge i_clock);
		#1;
		chk_reg(o_reg_rdata, exp);
	endtask
	task do_reset(input int n);
		@(posedge i_clock);
		i_rst <= 1'b1;
		repeat (n) @(posedge i_clock);
		i_rst <= 1'b0;
	endtask
	// bounded wait until a clock count after reset, then settle
	task wait_to(input int t);
		for (int k = 0; k < 200000 && clk_n < t; k++) @(posedge i_clock);
		if (clk_n < t) begin
			fail_count++;
			results();
		end
		#1;
	endtask
	// on for cycles 0..s of a gated slot, static at the top setting
	function automatic logic [16:0] exp_pins(input int c);
		for (int p = 0; p < 17; p++)
			exp_pins[p] = (st[p] == SET_STATIC || c <= st[p]) ? pat[p] : ~pat[p];
	endfunction

	task t_reset_regs;
		rd(ADDR_PAT1_LOW, RST_PATTERN);
		rd(ADDR_PAT1_HIGH, RST_PATTERN);
		rd(ADDR_MASTER, RST_INTENSITY);
		rd(ADDR_INT_LAST, RST_INTENSITY);
		wr(8'h20, 8'h5A);
		rd(8'h20, READ_ZERO);
	endtask
	task t_regs;
		wr(ADDR_PAT1_LOW, 8'h5A);
		wr(ADDR_PAT1_HIGH, 8'hC3);
		wr(ADDR_INT_LAST, 8'h9E);
		rd(ADDR_PAT1_LOW, 8'h5A);
		rd(ADDR_PAT1_HIGH, 8'hC3);
		rd(ADDR_INT_LAST, 8'h9E);
	endtask
	// master 0: static levels, every blink combination
	task t_blink;
		logic ph;
		i_phase0_pattern <= 16'h00F0;
		i_o16_phase1 <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			@(posedge i_clock);
			i_blink_enable <= k[2];
			i_blink_flip <= k[1];
			i_blink_pin <= k[0];
			repeat (3) @(posedge i_clock);
			#1;
			ph = k[2] & (k[1] ^ k[0]);
			chk_pin(pins, ph ? 17'h1C35A : 17'h000F0);
		end
	endtask
	// fresh timebase, slot 0 gated only, per-port then global duty
	task t_pwm;
		do_reset(2);
		i_blink_enable <= 1'b0;
		i_o16_phase0 <= 1'b0;
		i_phase0_pattern <= 16'h0010;
		wr(ADDR_MASTER, 8'h10);
		wr(ADDR_INT_FIRST, 8'h20);
		wr(8'h11, 8'hFF);
		pat = 17'h00010;
		foreach (st[p]) st[p] = 4'h0;
		st[1] = 4'h2;
		st[2] = SET_STATIC;
		st[3] = SET_STATIC;
		for (int c = 0; c < 5; c++) begin
			wait_to(c * CYC_CLKS + CYC_CLKS / 2);
			chk_pin(pins, exp_pins(c));
		end
		@(posedge i_clock);
		i_global_mode <= 1'b1;
		wr(ADDR_MASTER, 8'h16);
		foreach (st[p]) st[p] = 4'h6;
		for (int c = 5; c < 8; c++) begin
			wait_to(c * CYC_CLKS + CYC_CLKS / 2);
			chk_pin(pins, exp_pins(c));
		end
		wait_to(16 * CYC_CLKS + CYC_CLKS / 2);
		chk_pin(pins, ~pat);
	endtask

	initial begin
		// reset held from time zero so no check sees unknown state
		{i_rst, i_reg_wr, i_global_mode, i_blink_enable} = 4'h8;
		{i_blink_flip, i_blink_pin, i_o16_phase0, i_o16_phase1} = 4'h0;
		i_reg_addr = 8'h00;
		i_reg_wdata = 8'h00;
		i_phase0_pattern = 16'hFFFF;
		fail_count = 0;
		n_tests = 0;
		do_reset(20);
		t_reset_regs();
		t_regs();
		t_blink();
		t_pwm();
		results();
	end
endmodule
